// ### hdl/trbg_top.sv
`timescale 1ns/1ns
module trbg_top #(
    parameter int NB_DIV = trbg_pkg::CLK_HZ / trbg_pkg::NB_SPS,
    parameter int WB_DIV = trbg_pkg::CLK_HZ / trbg_pkg::WB_SPS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_first,
    input wire logic [7:0] cmd_byte,
    input wire logic wideband,
    input wire logic ring_active,
    input wire logic zero_cross_ring_control,
    input wire logic line_polarity_control,
    input wire logic signed [15:0] open_circuit_voltage,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output logic sample_valid,
    output logic signed [20:0] sample_out,
    output logic line_connect
);
    import trbg_pkg::*;

    trbg_cmd_e cmd_reg;
    logic [3:0] idx_reg;
    logic [79:0] wr_buf_reg;
    logic [87:0] rd_shift_reg;
    logic [87:0] gen_params_reg;
    logic [7:0] ctl_reg;
    logic en_a_prev_reg;
    logic commit_dly_reg;
    logic [15:0] div_reg;
    logic tick_reg;
    logic [16:0] phase_a_reg;
    logic [16:0] phase_b_reg;
    logic [24:0] prog_reg;
    logic signed [18:0] seg_from_reg;
    logic signed [18:0] seg_delta_reg;
    logic [15:0] trap_cnt_reg;
    logic trap_up_reg;
    logic signed [18:0] a_level_reg;
    logic signed [18:0] b_level_reg;
    logic diff_neg_reg;
    logic rd_valid_reg;
    logic [7:0] rd_byte_reg;
    logic sample_valid_reg;
    logic signed [20:0] sample_reg;
    logic line_connect_reg;

    // field views of the stored parameter block and control byte
    wire ramp_dir = gen_params_reg[F_RAMP_DIR];
    wire cont_ramp = gen_params_reg[F_CONT_RAMP];
    wire sine_or_trapezoid_select = gen_params_reg[F_SINE_OR_TRAPEZOID_SELECT];
    wire signed [15:0] bias = gen_params_reg[F_BIAS_LSB +: 16];
    wire [14:0] gen_a_frequency = gen_params_reg[F_GEN_A_FREQUENCY_LSB +: 15];
    wire signed [15:0] gen_a_amplitude = gen_params_reg[F_GEN_A_AMPLITUDE_LSB +: 16];
    wire [14:0] gen_b_frequency = gen_params_reg[F_GEN_B_FREQUENCY_LSB +: 15];
    wire signed [15:0] gen_b_amplitude = gen_params_reg[F_GEN_B_AMPLITUDE_LSB +: 16];
    wire en_a = ctl_reg[C_EN_A];
    wire en_b = ctl_reg[C_EN_B];
    wire en_bias = ctl_reg[C_EN_BIAS];

    // command decode
    wire data_in = cmd_valid && !cmd_first;
    wire gen_commit = data_in && cmd_reg == TRBG_WR_GEN && idx_reg == GEN_LAST_IDX;
    wire ctl_write = data_in && cmd_reg == TRBG_WR_CTL;
    wire [87:0] gen_new = {wr_buf_reg, cmd_byte} & ~GEN_RSVD;
    wire [7:0] ctl_new = cmd_byte & ~CTL_RSVD;
    wire rd_step = data_in && (cmd_reg == TRBG_RD_GEN || cmd_reg == TRBG_RD_CTL);
    trbg_cmd_e cmd_next;
    assign cmd_next = !cmd_first ? cmd_reg
        : cmd_byte == CMD_GEN_WR ? TRBG_WR_GEN
        : cmd_byte == CMD_GEN_RD ? TRBG_RD_GEN
        : cmd_byte == CMD_CTL_WR ? TRBG_WR_CTL
        : cmd_byte == CMD_CTL_RD ? TRBG_RD_CTL : TRBG_IDLE;

    // ramp restart: a write restarts one cycle late so it sees the new fields
    wire en_a_rise = en_a && !en_a_prev_reg;
    wire restart = commit_dly_reg || en_a_rise;
    wire signed [18:0] amp_eff = ramp_dir ? -19'(gen_a_amplitude) : 19'(gen_a_amplitude);

    // sample clock divider
    wire [15:0] div_last = wideband ? 16'(WB_DIV - 1) : 16'(NB_DIV - 1);
    wire tick = div_reg >= div_last; // a rate switch never strands the count above the end

    // sine phase steps scaled to 0.3662 Hz per unit at either rate
    wire [2:0] pmul = wideband ? WB_PHASE_MUL : NB_PHASE_MUL;
    wire [17:0] inc_a = gen_a_frequency * pmul;
    wire [17:0] inc_b = gen_b_frequency * pmul;

    // edge progress per sample, halved in wideband to keep time constant
    wire [10:0] prog_mul = cont_ramp ? RAMP_PROG_MUL : TRAP_PROG_MUL;
    wire [25:0] prog_step_nb = gen_a_frequency * prog_mul;
    wire [25:0] prog_step = wideband ? {1'b0, prog_step_nb[25:1]} : prog_step_nb;
    wire [26:0] prog_sum = {2'b00, prog_reg} + {1'b0, prog_step};
    wire prog_sat = prog_sum >= {2'b00, PROG_FULL};
    wire [24:0] prog_next = prog_sat ? PROG_FULL : prog_sum[24:0];

    // trapezoid half-period in samples; zero period freezes the edge
    wire [13:0] half_per = gen_b_frequency[14:1];
    wire trap_flip = sine_or_trapezoid_select && !cont_ramp && half_per != 14'h0000
        && trap_cnt_reg + 16'h0001 >= {2'b00, half_per};
    wire signed [18:0] trap_target = trap_up_reg ? -amp_eff : amp_eff;

    // waveform shaping for both generators
    logic signed [18:0] wave_a;
    logic signed [18:0] wave_b;
    trbg_wave u_wave_a (
        .phase(sine_or_trapezoid_select ? prog_reg[24:8] : phase_a_reg),
        .amp(sine_or_trapezoid_select ? seg_delta_reg : amp_eff),
        .use_sine(!sine_or_trapezoid_select),
        .value(wave_a)
    );
    trbg_wave u_wave_b (
        .phase(phase_b_reg),
        .amp(19'(gen_b_amplitude)),
        .use_sine(1'b1),
        .value(wave_b)
    );
    wire signed [18:0] a_next = sine_or_trapezoid_select ? seg_from_reg + wave_a : wave_a;
    wire signed [18:0] b_next = sine_or_trapezoid_select ? 19'sh00000 : wave_b;

    // output sum; during ringing only generator A and bias are used
    wire signed [20:0] a_part = en_a ? 21'(a_level_reg) : 21'sh000000;
    wire signed [20:0] b_part = (en_b && !ring_active) ? 21'(b_level_reg) : '0;
    wire signed [20:0] bias_part = en_bias ? 21'(bias) : 21'sh000000;
    wire signed [20:0] sum = a_part + b_part + bias_part;
    wire signed [20:0] sum_pol = line_polarity_control ? -sum : sum;
    wire signed [21:0] voc_diff = 22'(sum_pol) - 22'(open_circuit_voltage);
    wire voc_neg = voc_diff[21];

    // command byte sequencing and parameter storage
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_reg <= TRBG_IDLE;
            idx_reg <= 4'h0;
            wr_buf_reg <= 80'h0;
            gen_params_reg <= GEN_RESET;
            ctl_reg <= CTL_RESET;
            en_a_prev_reg <= 1'b0;
            commit_dly_reg <= 1'b0;
        end else begin
            cmd_reg <= gen_commit ? TRBG_IDLE : cmd_next;
            idx_reg <= cmd_first ? 4'h0 : (data_in ? idx_reg + 4'h1 : idx_reg);
            if (data_in && cmd_reg == TRBG_WR_GEN) begin
                wr_buf_reg <= {wr_buf_reg[71:0], cmd_byte};
            end
            // block only takes effect once all eleven bytes arrived
            if (gen_commit) begin
                gen_params_reg <= gen_new;
            end
            if (ctl_write) begin
                ctl_reg <= ctl_new;
            end
            en_a_prev_reg <= en_a;
            commit_dly_reg <= gen_commit;
        end
    end

    // readback shifts one byte out per host data strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_shift_reg <= 88'h0;
            rd_valid_reg <= 1'b0;
            rd_byte_reg <= 8'h00;
        end else begin
            rd_valid_reg <= rd_step;
            if (cmd_first && cmd_byte == CMD_GEN_RD) begin
                rd_shift_reg <= gen_params_reg;
            end else if (cmd_first && cmd_byte == CMD_CTL_RD) begin
                rd_shift_reg <= {ctl_reg, 80'h0};
            end else if (rd_step) begin
                rd_shift_reg <= {rd_shift_reg[79:0], 8'h00};
            end
            if (rd_step) begin
                rd_byte_reg <= rd_shift_reg[87:80];
            end
        end
    end

    // sample rate divider
    always_ff @(posedge mclk) begin
        if (rst || tick) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
        tick_reg <= !rst && tick;
    end

    // generator state: restart wins over the sample step
    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_a_reg <= 17'h00000;
            phase_b_reg <= 17'h00000;
            prog_reg <= 25'h0000000;
            seg_from_reg <= 19'sh00000;
            seg_delta_reg <= 19'sh00000;
            trap_cnt_reg <= 16'h0000;
            trap_up_reg <= 1'b1;
            a_level_reg <= 19'sh00000;
            b_level_reg <= 19'sh00000;
        end else if (restart) begin
            phase_a_reg <= 17'h00000;
            phase_b_reg <= commit_dly_reg ? 17'h00000 : phase_b_reg;
            prog_reg <= 25'h0000000;
            trap_cnt_reg <= 16'h0000;
            trap_up_reg <= 1'b1;
            seg_delta_reg <= amp_eff;
            // a ramp continues from where an enabled A sits; else it starts at zero
            seg_from_reg <= (cont_ramp && en_a_prev_reg) ? a_level_reg : 19'sh00000;
        end else if (tick) begin
            phase_a_reg <= phase_a_reg + inc_a[16:0];
            phase_b_reg <= phase_b_reg + inc_b[16:0];
            a_level_reg <= a_next;
            b_level_reg <= b_next;
            if (trap_flip) begin
                trap_cnt_reg <= 16'h0000;
                trap_up_reg <= !trap_up_reg;
                seg_from_reg <= a_next;
                seg_delta_reg <= trap_target - a_next;
                prog_reg <= 25'h0000000;
            end else begin
                trap_cnt_reg <= trap_cnt_reg + 16'h0001;
                prog_reg <= prog_next;
            end
        end
    end

    // output sample and zero-cross line connection
    always_ff @(posedge mclk) begin
        if (rst) begin
            sample_valid_reg <= 1'b0;
            sample_reg <= 21'sh000000;
            diff_neg_reg <= 1'b0;
            line_connect_reg <= 1'b0;
        end else begin
            sample_valid_reg <= tick_reg;
            if (tick_reg) begin
                sample_reg <= sum_pol;
                diff_neg_reg <= voc_neg;
            end
            // relay hazard: connecting off-crossing gives a current spike
            if (!ring_active) begin
                line_connect_reg <= 1'b0;
            end else if (zero_cross_ring_control) begin
                line_connect_reg <= 1'b1;
            end else if (tick_reg && voc_neg != diff_neg_reg) begin
                line_connect_reg <= 1'b1;
            end
        end
    end

    assign rd_valid = rd_valid_reg;
    assign rd_byte = rd_byte_reg;
    assign sample_valid = sample_valid_reg;
    assign sample_out = sample_reg;
    assign line_connect = line_connect_reg;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_block_commit: assert property (gen_commit
        |=> gen_params_reg[7:0] == $past(cmd_byte))
        else $error("parameter block not committed");
    chk_rsvd_clear: assert property ((gen_params_reg & GEN_RSVD) == 88'h0)
        else $error("reserved bit stored");
    chk_ramp_sign: assert property (restart
        |=> seg_delta_reg == ($past(ramp_dir) ? -19'($past(gen_a_amplitude)) : 19'($past(gen_a_amplitude))))
        else $error("ramp delta sign wrong");
    chk_restart_from: assert property (restart && cont_ramp && en_a_prev_reg
        |=> prog_reg == 25'h0 && seg_from_reg == $past(a_level_reg))
        else $error("ramp did not restart from level");
    chk_trap_b_quiet: assert property (tick && sine_or_trapezoid_select && !restart
        |=> b_level_reg == 19'sh0)
        else $error("generator B active in trapezoid");
    chk_reset_load: assert property ($fell(rst) |-> gen_params_reg == GEN_RESET)
        else $error("reset value wrong");
    chk_enable_gate: assert property (tick && ctl_reg == 8'h00 ##1 ctl_reg == 8'h00
        |=> sample_valid && sample_out == 21'sh0)
        else $error("disabled sources reached output");
    chk_sample_space: assert property (sample_valid |=> !sample_valid [*8])
        else $error("samples too close");
    chk_ring_drop: assert property (!ring_active |=> !line_connect)
        else $error("line connected without ringing");
    chk_pol_sign: assert property (tick_reg && line_polarity_control
        |=> sample_out == -$past(sum))
        else $error("polarity not applied");

    cov_param_write: cover property (gen_commit);
    cov_trap_flip: cover property (tick && trap_flip);
    cov_ring_connect: cover property ($rose(line_connect) && !zero_cross_ring_control);
    cov_readback: cover property (rd_valid && cmd_reg == TRBG_RD_GEN);
endmodule

// ### pkg/trbg_pkg.sv
package trbg_pkg;
    // command codes on the byte-serial control port
    localparam logic [7:0] CMD_GEN_WR = 8'hD2;
    localparam logic [7:0] CMD_GEN_RD = 8'hD3;
    localparam logic [7:0] CMD_CTL_WR = 8'hDE;
    localparam logic [7:0] CMD_CTL_RD = 8'hDF;
    localparam int GEN_BYTES = 11;
    localparam int GEN_BITS = 88;
    localparam logic [3:0] GEN_LAST_IDX = 4'hA;
    // field positions inside the 88-bit parameter block
    localparam int F_RAMP_DIR = 82;
    localparam int F_CONT_RAMP = 81;
    localparam int F_SINE_OR_TRAPEZOID_SELECT = 80;
    localparam int F_BIAS_LSB = 64;
    localparam int F_GEN_A_FREQUENCY_LSB = 48;
    localparam int F_GEN_A_AMPLITUDE_LSB = 32;
    localparam int F_GEN_B_FREQUENCY_LSB = 16;
    localparam int F_GEN_B_AMPLITUDE_LSB = 0;
    localparam logic [87:0] GEN_RESET = 88'h00_0000_0037_4AA4_0000_0000;
    localparam logic [87:0] GEN_RSVD = 88'hF8_0000_8000_0000_8000_0000;
    // generator control byte
    localparam int C_EN_A = 0;
    localparam int C_EN_B = 1;
    localparam int C_EN_BIAS = 4;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_RSVD = 8'h20;
    // sample timing
    localparam int CLK_HZ = 125_000_000;
    localparam int NB_SPS = 8000;
    localparam int WB_SPS = 16000;
    // phase step per frequency unit: 0.3662 Hz on a 17-bit accumulator
    localparam logic [2:0] NB_PHASE_MUL = 3'h6;
    localparam logic [2:0] WB_PHASE_MUL = 3'h3;
    // edge progress per unit: 2^24 / (2.73 * 8000) and 2^24 / (1.365 * 8000)
    localparam logic [10:0] TRAP_PROG_MUL = 11'h300;
    localparam logic [10:0] RAMP_PROG_MUL = 11'h600;
    localparam logic [24:0] PROG_FULL = 25'h1000000;

    typedef enum logic [2:0] {
        TRBG_IDLE = 3'b000,
        TRBG_WR_GEN = 3'b001,
        TRBG_RD_GEN = 3'b011,
        TRBG_WR_CTL = 3'b010,
        TRBG_RD_CTL = 3'b110
    } trbg_cmd_e;
endpackage

// ### hdl/trbg_wave.sv
`timescale 1ns/1ns
// scales a signed amplitude by a parabolic sine or a linear fraction
module trbg_wave (
    input wire logic [16:0] phase,
    input wire logic signed [18:0] amp,
    input wire logic use_sine,
    output logic signed [18:0] value
);
    logic [15:0] t;
    logic [16:0] t_rest;
    logic [32:0] par_full;
    logic [16:0] frac;
    logic signed [36:0] prod;
    logic signed [18:0] scaled;

    // parabola t*(1-t) peaks at 0x10000 mid half-cycle; cheap, no table
    assign t = phase[15:0];
    assign t_rest = 17'h10000 - {1'b0, t};
    assign par_full = {17'h00000, t} * {16'h0000, t_rest};
    assign frac = use_sine ? par_full[30:14] : phase;
    assign prod = amp * $signed({1'b0, frac});
    assign scaled = prod[34:16];
    // second half of the sine cycle is the mirror below zero
    assign value = (use_sine && phase[16]) ? -scaled : scaled;
endmodule

// ### bench/trbg_host_model.sv
`timescale 1ns/1ns
// host side of the byte-serial command port; every change lands just after a rising edge
module trbg_host_model
    import trbg_pkg::*;
(
    input wire logic mclk,
    input wire logic rd_valid,
    input wire logic [7:0] rd_byte,
    output logic cmd_valid,
    output logic cmd_first,
    output logic [7:0] cmd_byte
);
    initial begin
        cmd_valid = 1'b0;
        cmd_first = 1'b0;
        cmd_byte = 8'hA5;
    end

    // one byte strobe, held until the next edge samples it
    task automatic send(input logic f, input logic [7:0] b);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_first <= f;
        cmd_byte <= b;
    endtask

    // released data lines toggle so a stale byte never looks valid
    task automatic idle();
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_first <= 1'b0;
        cmd_byte <= ~cmd_byte;
    endtask

    // n below eleven leaves the write unfinished for the next command to cut
    task automatic write_blk(input logic [7:0] cmd, input logic [87:0] blk, input int n);
        logic [87:0] b;
        b = blk & ~GEN_RSVD;
        if (b[F_CONT_RAMP]) begin
            b[F_SINE_OR_TRAPEZOID_SELECT] = 1'b1;
        end
        send(1'b1, cmd);
        for (int i = 0; i < n; i++) begin
            send(1'b0, b[87 - 8 * i -: 8]);
        end
        idle();
    endtask

    task automatic write_ctl(input logic [7:0] c);
        send(1'b1, CMD_CTL_WR);
        send(1'b0, c & ~CTL_RSVD);
        idle();
    endtask

    // one strobe per byte, answer taken at the edge that shows rd_valid high
    task automatic read_blk(output logic [87:0] b, output int miss);
        logic got;
        b = '0;
        miss = 0;
        send(1'b1, CMD_GEN_RD);
        idle();
        for (int i = 0; i < GEN_BYTES; i++) begin
            send(1'b0, 8'h00);
            idle();
            got = 1'b0;
            for (int k = 0; k < 4 && !got; k++) begin
                @(posedge mclk);
                got = (rd_valid === 1'b1);
            end
            // a missing answer is counted so the bench can flag it
            if (!got) begin
                miss++;
            end
            b[87 - 8 * i -: 8] = rd_byte;
        end
    endtask
endmodule

// ### bench/trbg_top_bench.sv
`timescale 1ns/1ns
// short sample dividers keep the run brief; all expectations use them
module trbg_top_bench;
    import trbg_pkg::*;
    localparam int NBD = 20;
    localparam int WBD = 10;
    logic mclk, rst, wideband, ring_active, zero_cross_ring_control, line_polarity_control;
    logic signed [15:0] open_circuit_voltage;
    wire logic cmd_valid, cmd_first;
    wire logic [7:0] cmd_byte;
    logic rd_valid, sample_valid, line_connect;
    logic [7:0] rd_byte;
    logic signed [20:0] sample_out, s;
    logic [87:0] blk;
    int err_count, total_checks, gap;

    trbg_top #(.NB_DIV(NBD), .WB_DIV(WBD)) u_dut (.mclk(mclk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_first(cmd_first), .cmd_byte(cmd_byte),
        .wideband(wideband), .ring_active(ring_active),
        .zero_cross_ring_control(zero_cross_ring_control),
        .line_polarity_control(line_polarity_control),
        .open_circuit_voltage(open_circuit_voltage), .rd_valid(rd_valid),
        .rd_byte(rd_byte), .sample_valid(sample_valid), .sample_out(sample_out),
        .line_connect(line_connect));
    trbg_host_model u_host (.mclk(mclk), .rd_valid(rd_valid), .rd_byte(rd_byte),
        .cmd_valid(cmd_valid), .cmd_first(cmd_first), .cmd_byte(cmd_byte));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic compare(input logic [20:0] got, input logic [20:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // reserved bits are masked since their readback is not promised
    task automatic check_blk(input logic [87:0] exp);
        int miss;
        u_host.read_blk(blk, miss);
        compare(21'(miss), 21'h0);
        for (int i = 0; i < GEN_BYTES; i++) begin
            compare(21'((blk & ~GEN_RSVD) >> (80 - 8 * i)) & 21'hFF,
                21'((exp & ~GEN_RSVD) >> (80 - 8 * i)) & 21'hFF);
        end
    endtask

    // bounded wait for the next sample pulse; gap counts edges since the call
    task automatic next_sample();
        gap = 0;
        while (gap < 200) begin
            @(posedge mclk);
            gap++;
            if (sample_valid === 1'b1) begin
                break;
            end
        end
        s = sample_out;
        compare(21'(sample_valid), 21'h1);
    endtask

    task automatic t_ramp();
        u_host.write_blk(CMD_GEN_WR, 88'h02_0000_2000_1000_0000_0000, 11);
        u_host.write_ctl(8'h01);
        repeat (6) next_sample();
        compare(s, 21'h001000);
        u_host.write_blk(CMD_GEN_WR, 88'h07_0000_2000_1000_0000_0000, 11);
        repeat (6) next_sample();
        compare(s, 21'h000000);
    endtask

    task automatic t_readback();
        u_host.write_ctl(8'h00);
        u_host.write_blk(CMD_GEN_WR, 88'h03_1234_1ABC_8001_2345_7FFE, 11);
        check_blk(88'h03_1234_1ABC_8001_2345_7FFE);
        u_host.write_blk(CMD_GEN_WR, 88'h00_FFFF_0FFF_FFFF_0FFF_FFFF, 5);
        check_blk(88'h03_1234_1ABC_8001_2345_7FFE);
    endtask

    task automatic t_bias();
        u_host.write_blk(CMD_GEN_WR, 88'h00_8123_0000_0000_0000_0000, 11);
        u_host.write_ctl(8'h10);
        repeat (2) next_sample();
        compare(s, 21'h1F8123);
        compare(21'(gap), 21'(NBD));
        @(posedge mclk);
        line_polarity_control <= 1'b1;
        wideband <= 1'b1;
        repeat (3) next_sample();
        compare(s, -21'h1F8123);
        compare(21'(gap), 21'(WBD));
        @(posedge mclk);
        line_polarity_control <= 1'b0;
        wideband <= 1'b0;
    endtask

    // third sample lies well inside the first half period of the sine
    task automatic sine_sign(input logic [87:0] b, input logic [7:0] ctl, input logic pos);
        u_host.write_blk(CMD_GEN_WR, b, 11);
        u_host.write_ctl(ctl);
        repeat (3) next_sample();
        compare(21'(pos ? s > 0 : s < 0), 21'h1);
    endtask

    task automatic t_sines();
        sine_sign(88'h00_0000_0000_0000_0100_2000, 8'h02, 1'b1);
        sine_sign(88'h00_0000_0000_0000_0100_E000, 8'h02, 1'b0);
        sine_sign(88'h00_0000_0100_2000_0000_0000, 8'h01, 1'b1);
        sine_sign(88'h04_0000_0100_2000_0000_0000, 8'h01, 1'b0);
        u_host.write_blk(CMD_GEN_WR, 88'h01_0000_0000_0000_0100_2000, 11);
        repeat (3) next_sample();
        compare(s, 21'h0);
    endtask

    task automatic t_ring();
        u_host.write_blk(CMD_GEN_WR, 88'h00_0000_0000_0000_0100_2000, 11);
        @(posedge mclk);
        zero_cross_ring_control <= 1'b1;
        ring_active <= 1'b1;
        repeat (2) @(posedge mclk);
        compare(21'(line_connect), 21'h1);
        repeat (3) next_sample();
        compare(s, 21'h0);
        ring_active <= 1'b0;
        repeat (2) @(posedge mclk);
        compare(21'(line_connect), 21'h0);
    endtask

    // crossing level settles before ringing so a stale sign cannot fake a crossing;
    // the sine of A stays below 1000h for its first seven samples, then rises above
    task automatic t_zero_cross();
        zero_cross_ring_control <= 1'b0;
        open_circuit_voltage <= 16'sh1000;
        repeat (2) next_sample();
        u_host.write_blk(CMD_GEN_WR, 88'h00_0000_0100_2000_0000_0000, 11);
        u_host.write_ctl(8'h00);
        u_host.write_ctl(8'h01);
        ring_active <= 1'b1;
        repeat (3) next_sample();
        compare(21'(line_connect), 21'h0);
        repeat (12) next_sample();
        compare(21'(line_connect), 21'h1);
        ring_active <= 1'b0;
        open_circuit_voltage <= 16'sh0000;
        repeat (2) @(posedge mclk);
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog sized well above the 52 samples the tests wait for
    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        give_verdict();
    end

    initial begin
        err_count = 0;
        total_checks = 0;
        rst = 1'b1;
        wideband = 1'b0;
        ring_active = 1'b0;
        zero_cross_ring_control = 1'b0;
        line_polarity_control = 1'b0;
        open_circuit_voltage = 16'sh0000;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check_blk(GEN_RESET);
        t_ramp();
        t_readback();
        t_bias();
        t_sines();
        t_ring();
        t_zero_cross();
        give_verdict();
    end
endmodule
